// >>> sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import dira_pkg::*;

	// ==========================================================
	// Stimulus and observation signals
	localparam int UNIT = 10;
	logic                      i_clk;
	logic                      i_rst;
	dira_req_type              req;
	logic [1:0]                err;
	logic [7:0]                rdata;
	logic                      rvalid;
	dira_phy_timing_type [1:0] timing;
	logic [1:0]                init_done;
	logic [7:0]                exp_q[$];
	logic [7:0]                vals[8];
	logic [7:0]                rst_v[4];
	int                        mismatches;
	int                        comparisons;
	int                        seed;
	int                        n;

	// Short init unit keeps the power-up wait to a few cycles
	dira_indirect_regs #(
		.BANK_DEPTH   (DIRA_BANK_DEPTH),
		.INIT_UNIT_CYC(UNIT)
	) i_dut (
		.i_clk      (i_clk),
		.i_rst      (i_rst),
		.i_req      (req),
		.o_rdata    (rdata),
		.o_rvalid   (rvalid),
		.i_proto_err(err),
		.o_timing   (timing),
		.o_init_done(init_done)
	);

	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end

	// ==========================================================
	// Checking and bus tasks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp,
			input string m);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, m,
				got, exp);
		end
	endtask

	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Strobes stay up between back-to-back calls; idle drops them
	task automatic bus(input logic w, input logic r, input logic [7:0] a,
			input logic [7:0] d);
		req.wr = w;
		req.rd = r;
		req.addr = a;
		req.wdata = d;
		@(posedge i_clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, 1'b0, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		bus(1'b0, 1'b1, a, 8'h00);
	endtask

	task automatic idle(input int c);
		req = '0;
		repeat (c) begin
			@(posedge i_clk);
			#1;
		end
	endtask

	task automatic pulse(input logic [1:0] p, input int c);
		repeat (c) begin
			err = p;
			@(posedge i_clk);
			#1;
			err = 2'b00;
			@(posedge i_clk);
			#1;
		end
	endtask

	// Read answers are matched in order of issue
	always @(negedge i_clk) begin
		if (rvalid === 1'b1) begin
			if (exp_q.size() == 0) begin
				chk(rdata, 8'hxx, "unexpected read answer");
			end else begin
				chk(rdata, exp_q.pop_front(), "read data");
			end
		end
	end

	// ==========================================================
	// Main sequence
	initial begin
		seed = 32'hc8e2;
		mismatches = 0;
		comparisons = 0;
		req = '0;
		err = 2'b00;
		i_rst = 1'b1;
		rst_v = '{8'h00, 8'h00, 8'h00, 8'h1d};
		repeat (12) @(posedge i_clk);
		#1;
		i_rst = 1'b0;
		chk({6'h00, init_done}, 8'h00, "init done in reset");
		n = 0;
		while (init_done !== 2'b11 && n < 40) begin
			@(posedge i_clk);
			#1;
			n++;
		end
		chk(8'(n >= UNIT - 2 && n <= UNIT + 4), 8'h01, "init wait");
		if (n >= 40) begin
			wrap_up;
		end
		chk({1'b0, timing[1].clk_settle}, 8'h1d, "settle reset");
		// Reset values of both banks, auto-increment reads
		for (int p = 0; p < 2; p++) begin
			wr(DIRA_ADDR_CTL, p ? 8'h0b : 8'h07);
			wr(DIRA_ADDR_OFS, 8'h00);
			for (int k = 0; k < 4; k++) begin
				rd(DIRA_ADDR_DATA, rst_v[k]);
			end
		end
		rd(DIRA_ADDR_CTL, 8'h0b);
		rd(DIRA_ADDR_OFS, 8'h04);
		wr(8'h43, 8'hff);
		rd(8'h43, 8'h00);
		rd(DIRA_ADDR_CTL, 8'h0b);
		// Port 0 timing fields, random values, upper bits dropped
		for (int i = 0; i < 3; i++) begin
			vals[i] = 8'($random(seed));
		end
		wr(DIRA_ADDR_CTL, 8'h06);
		wr(DIRA_ADDR_OFS, 8'h01);
		for (int i = 0; i < 3; i++) begin
			wr(DIRA_ADDR_DATA, vals[i]);
		end
		idle(2);
		chk({5'h00, timing[0].init_wait}, {5'h00, vals[0][2:0]}, "init");
		chk({5'h00, timing[0].term_count}, {5'h00, vals[1][2:0]}, "term");
		chk({1'b0, timing[0].clk_settle}, {1'b0, vals[2][6:0]}, "settle");
		chk({1'b0, timing[1].clk_settle}, 8'h1d, "port 1 settle");
		chk({6'h00, init_done}, 8'h03, "init done holds");
		wr(DIRA_ADDR_CTL, 8'h07);
		wr(DIRA_ADDR_OFS, 8'h01);
		rd(DIRA_ADDR_DATA, {5'h00, vals[0][2:0]});
		rd(DIRA_ADDR_DATA, {5'h00, vals[1][2:0]});
		rd(DIRA_ADDR_DATA, {1'b0, vals[2][6:0]});
		// Read mode refuses data writes; no auto-increment repeats offset
		wr(DIRA_ADDR_CTL, 8'h05);
		wr(DIRA_ADDR_OFS, 8'h03);
		wr(DIRA_ADDR_DATA, 8'h77);
		rd(DIRA_ADDR_DATA, {1'b0, vals[2][6:0]});
		rd(DIRA_ADDR_DATA, {1'b0, vals[2][6:0]});
		// Port 1 write leaves port 0 alone; write mode reads zero
		vals[3] = 8'($random(seed));
		wr(DIRA_ADDR_CTL, 8'h08);
		wr(DIRA_ADDR_OFS, 8'h02);
		wr(DIRA_ADDR_DATA, vals[3]);
		rd(DIRA_ADDR_DATA, 8'h00);
		idle(2);
		chk({5'h00, timing[1].term_count}, {5'h00, vals[3][2:0]}, "p1 term");
		chk({5'h00, timing[0].term_count}, {5'h00, vals[1][2:0]}, "p0 term");
		// Plain port 0 write select; offset still at the term field
		vals[4] = 8'($random(seed));
		wr(DIRA_ADDR_CTL, 8'h04);
		wr(DIRA_ADDR_DATA, vals[4]);
		idle(2);
		chk({5'h00, timing[0].term_count}, {5'h00, vals[4][2:0]}, "p0 wr");
		chk({5'h00, timing[1].term_count}, {5'h00, vals[3][2:0]}, "p1 kept");
		// Plain storage burst on port 1
		for (int i = 0; i < 8; i++) begin
			vals[i] = 8'($random(seed));
		end
		// Eight auto-increment writes from offset 0x30, then read back in order
		wr(DIRA_ADDR_CTL, 8'h0a);
		wr(DIRA_ADDR_OFS, 8'h30);
		for (int i = 0; i < 8; i++) begin
			wr(DIRA_ADDR_DATA, vals[i]);
		end
		wr(DIRA_ADDR_CTL, 8'h0b);
		wr(DIRA_ADDR_OFS, 8'h30);
		for (int i = 0; i < 8; i++) begin
			rd(DIRA_ADDR_DATA, vals[i]);
		end
		// Offset wraps past the top
		wr(DIRA_ADDR_OFS, 8'hff);
		rd(DIRA_ADDR_DATA, 8'h00);
		rd(DIRA_ADDR_OFS, 8'h00);
		// Error tallies: count, clear on read, saturate
		idle(1);
		pulse(2'b10, 3);
		pulse(2'b01, 300);
		wr(DIRA_ADDR_CTL, 8'h09);
		wr(DIRA_ADDR_OFS, 8'h00);
		rd(DIRA_ADDR_DATA, 8'h03);
		rd(DIRA_ADDR_DATA, 8'h00);
		wr(DIRA_ADDR_OFS, 8'h03);
		rd(DIRA_ADDR_DATA, 8'h1d);
		wr(DIRA_ADDR_OFS, 8'h00);
		wr(DIRA_ADDR_CTL, 8'h05);
		rd(DIRA_ADDR_DATA, 8'hff);
		rd(DIRA_ADDR_DATA, 8'h00);
		idle(4);
		n = 0;
		while (exp_q.size() != 0 && n < 10) begin
			idle(1);
			n++;
		end
		chk(8'(exp_q.size()), 8'h00, "reads left unanswered");
		wrap_up;
	end

endmodule
`default_nettype wire

// >>> src/dira_bank_mem.sv
`timescale 1ns/1ps
`default_nettype none
module dira_bank_mem #(
	parameter int AW = 7,
	parameter int DW = 8
) (
	// Clock and reset
	input  wire logic          i_clk,
	input  wire logic          i_rst,
	// Write side
	input  wire logic          i_we,
	input  wire logic [AW-1:0] i_waddr,
	input  wire logic [DW-1:0] i_wdata,
	// Read side
	input  wire logic          i_re,
	input  wire logic [AW-1:0] i_raddr,
	output logic      [DW-1:0] o_rdata
);
	import dira_pkg::*;

	if (AW < 1 || DW < 1) begin : g_bad_size
		$error("dira_bank_mem: AW and DW must be at least 1");
	end

	// ==========================================================
	// Storage; no reset so it maps onto plain RAM
	logic [DW-1:0] mem_q [2**AW];

	always_ff @(posedge i_clk) begin
		if (i_we) begin
			mem_q[i_waddr] <= i_wdata;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= '0;
		end else if (i_re) begin
			o_rdata <= mem_q[i_raddr];
		end
	end

endmodule
`default_nettype wire

// >>> src/dira_err_tally.sv
`timescale 1ns/1ps
`default_nettype none
module dira_err_tally (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	// Events and software access
	input  wire logic       i_err,
	input  wire logic       i_clr,
	input  wire logic       i_we,
	input  wire logic [7:0] i_wdata,
	// Tally
	output logic      [7:0] o_count
);
	import dira_pkg::*;

	// ==========================================================
	// Saturating tally; an error in the clearing cycle still counts
	wire       at_max = (o_count == DIRA_TALLY_MAX);
	wire [7:0] inc    = at_max ? o_count : o_count + DIRA_TALLY_ONE;
	wire [7:0] base   = i_clr ? DIRA_TALLY_RST : o_count;
	wire [7:0] cnt_d  = i_we ? i_wdata :
	                    i_err ? (i_clr ? DIRA_TALLY_ONE : inc) :
	                    base;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_count <= DIRA_TALLY_RST;
		end else begin
			o_count <= cnt_d;
		end
	end

	// ==========================================================
	// Checks
	chk_tally_read_clear: assert property (@(posedge i_clk) disable iff (i_rst)
		i_clr && !i_err && !i_we |=> o_count == DIRA_TALLY_RST)
		else $error("tally not cleared by read");

	chk_tally_counts_up: assert property (@(posedge i_clk) disable iff (i_rst)
		i_err && !i_clr && !i_we && !at_max
		|=> o_count == $past(o_count) + DIRA_TALLY_ONE)
		else $error("tally missed an error event");

endmodule
`default_nettype wire

// >>> src/dira_indirect_regs.sv
`timescale 1ns/1ps
`default_nettype none
module dira_indirect_regs #(
	parameter int BANK_DEPTH    = dira_pkg::DIRA_BANK_DEPTH,
	parameter int INIT_UNIT_CYC = dira_pkg::DIRA_INIT_UNIT_CYC
) (
	// Clock and reset
	input  wire logic                             i_clk,
	input  wire logic                             i_rst,
	// Main register space access
	input  wire dira_pkg::dira_req_type           i_req,
	output logic                           [7:0]  o_rdata,
	output logic                                  o_rvalid,
	// Interface error events, one per port
	input  wire logic                      [1:0]  i_proto_err,
	// PHY timing controls, one per port
	output var dira_pkg::dira_phy_timing_type [1:0] o_timing,
	output logic                           [1:0]  o_init_done
);
	import dira_pkg::*;

	localparam int NP     = DIRA_NPORT;
	localparam int MEM_AW = $clog2(BANK_DEPTH) + 1;

	if (BANK_DEPTH < 8 || BANK_DEPTH > 128 ||
	    (BANK_DEPTH & (BANK_DEPTH - 1)) != 0) begin : g_bad_depth
		$error("dira_indirect_regs: BANK_DEPTH must be 2**n in 8..128");
	end
	if (INIT_UNIT_CYC < 1) begin : g_bad_unit
		$error("dira_indirect_regs: INIT_UNIT_CYC must be at least 1");
	end

	// ==========================================================
	// Request decode
	// A write and a read in the same cycle: the write is taken alone.
	wire wr_take  = i_req.wr;
	wire rd_take  = i_req.rd & ~i_req.wr;
	wire hit_ctl  = (i_req.addr == DIRA_ADDR_CTL);
	wire hit_ofs  = (i_req.addr == DIRA_ADDR_OFS);
	wire hit_data = (i_req.addr == DIRA_ADDR_DATA);

	logic [7:0] ctl_q;
	logic [7:0] ofs_q;

	wire bank_ok  = dira_bank_valid(ctl_q);
	wire port     = dira_bank_port(ctl_q);
	wire rd_mode  = ctl_q[DIRA_CTL_RD_BIT];
	wire ainc     = ctl_q[DIRA_CTL_AINC_BIT];

	// Writes need write mode, reads need read mode; otherwise the bank is untouched and reads return zero, but auto-increment still steps the offset
	wire data_wr  = wr_take & hit_data & bank_ok & ~rd_mode;
	wire data_rd  = rd_take & hit_data & bank_ok & rd_mode;
	wire data_acc = (wr_take | rd_take) & hit_data;

	wire ofs_tally  = (ofs_q == DIRA_OFS_TALLY);
	wire ofs_init   = (ofs_q == DIRA_OFS_INIT);
	wire ofs_term   = (ofs_q == DIRA_OFS_TERM);
	wire ofs_settle = (ofs_q == DIRA_OFS_SETTLE);
	wire ofs_mem    = (ofs_q >= DIRA_OFS_MEM) &&
	                  ({1'b0, ofs_q} < 9'(BANK_DEPTH));

	// ==========================================================
	// Control and offset registers
	wire [7:0] ctl_d = (wr_take & hit_ctl) ? i_req.wdata : ctl_q;
	wire [7:0] ofs_d = (wr_take & hit_ofs) ? i_req.wdata :
	                   (data_acc & ainc) ? ofs_q + DIRA_OFS_STEP :
	                   ofs_q;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ctl_q <= DIRA_CTL_RST;
			ofs_q <= DIRA_OFS_RST;
		end else begin
			ctl_q <= ctl_d;
			ofs_q <= ofs_d;
		end
	end

	// ==========================================================
	// Per-port timing fields; writes land only in the selected port
	dira_phy_timing_type [NP-1:0] timing_q;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			for (int p = 0; p < NP; p++) begin
				timing_q[p].init_wait  <= DIRA_INIT_RST;
				timing_q[p].term_count <= DIRA_TERM_RST;
				timing_q[p].clk_settle <= DIRA_SETTLE_RST;
			end
		end else begin
			for (int p = 0; p < NP; p++) begin
				if (data_wr && port == 1'(p)) begin
					if (ofs_init) begin
						timing_q[p].init_wait <= i_req.wdata[2:0];
					end
					if (ofs_term) begin
						timing_q[p].term_count <= i_req.wdata[2:0];
					end
					if (ofs_settle) begin
						timing_q[p].clk_settle <= i_req.wdata[6:0];
					end
				end
			end
		end
	end

	assign o_timing = timing_q;

	// ==========================================================
	// Error tallies
	logic [7:0] tally_cnt [NP];

	for (genvar p = 0; p < NP; p++) begin : g_tally
		dira_err_tally u_tally (
			.i_clk   (i_clk),
			.i_rst   (i_rst),
			.i_err   (i_proto_err[p]),
			.i_clr   (data_rd && ofs_tally && port == 1'(p)),
			.i_we    (data_wr && ofs_tally && port == 1'(p)),
			.i_wdata (i_req.wdata),
			.o_count (tally_cnt[p])
		);
	end

	// ==========================================================
	// Plain bank storage for the remaining offsets, both ports in one
	// memory; the port bit is the top address bit so banks never alias.
	wire [MEM_AW-1:0] mem_addr = {port, ofs_q[MEM_AW-2:0]};
	logic [7:0] mem_rdata;

	dira_bank_mem #(
		.AW (MEM_AW),
		.DW (8)
	) u_mem (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_we    (data_wr & ofs_mem),
		.i_waddr (mem_addr),
		.i_wdata (i_req.wdata),
		.i_re    (data_rd & ofs_mem),
		.i_raddr (mem_addr),
		.o_rdata (mem_rdata)
	);

	// ==========================================================
	// Bank read mux; reserved bits read as zero
	dira_phy_timing_type sel_t;
	assign sel_t = timing_q[port];

	wire [7:0] bank_val =
		ofs_tally  ? tally_cnt[port] :
		ofs_init   ? {5'h00, sel_t.init_wait} :
		ofs_term   ? {5'h00, sel_t.term_count} :
		ofs_settle ? {1'b0, sel_t.clk_settle} :
		DIRA_RD_NONE;

	wire [7:0] direct_val =
		hit_ctl ? ctl_q :
		hit_ofs ? ofs_q :
		data_rd ? bank_val : DIRA_RD_NONE;

	// ==========================================================
	// Read pipeline: two cycles so memory and registers line up
	logic       s1_valid_q;
	logic       s1_mem_q;
	logic [7:0] s1_val_q;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s1_valid_q <= 1'b0;
			s1_mem_q   <= 1'b0;
			s1_val_q   <= DIRA_RD_NONE;
			o_rvalid   <= 1'b0;
			o_rdata    <= DIRA_RD_NONE;
		end else begin
			s1_valid_q <= rd_take;
			s1_mem_q   <= data_rd & ofs_mem;
			s1_val_q   <= direct_val;
			o_rvalid   <= s1_valid_q;
			o_rdata    <= s1_mem_q ? mem_rdata : s1_val_q;
		end
	end

	// ==========================================================
	// Init wait after reset, in 100 us units; done stays set once
	// reached, since later field writes do not restart power-up.
	logic [31:0] unit_cnt_q;
	logic [3:0]  units_q [NP];
	wire         unit_tick = (unit_cnt_q == 32'(INIT_UNIT_CYC - 1));

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			unit_cnt_q  <= '0;
			o_init_done <= '0;
			for (int p = 0; p < NP; p++) begin
				units_q[p] <= '0;
			end
		end else begin
			unit_cnt_q <= unit_tick ? '0 : unit_cnt_q + 32'd1;
			for (int p = 0; p < NP; p++) begin
				if (unit_tick && !o_init_done[p]) begin
					units_q[p] <= units_q[p] + DIRA_UNIT_ONE;
				end
				if (units_q[p] >= {1'b0, timing_q[p].init_wait}
				    + DIRA_UNIT_ONE) begin
					o_init_done[p] <= 1'b1;
				end
			end
		end
	end

	// ==========================================================
	// Checks
	logic [31:0] elapsed_q;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			elapsed_q <= '0;
		end else if (elapsed_q != '1) begin
			elapsed_q <= elapsed_q + 32'd1;
		end
	end

	chk_ctl_decode: assert property (@(posedge i_clk) disable iff (i_rst)
		wr_take && i_req.addr == DIRA_ADDR_CTL
		|=> ctl_q == $past(i_req.wdata))
		else $error("control register not loaded at its offset");

	chk_port0_write: assert property (@(posedge i_clk) disable iff (i_rst)
		ctl_q == DIRA_CTL_P0_WR && wr_take && hit_data && ofs_term
		|=> timing_q[0].term_count == $past(i_req.wdata[2:0]))
		else $error("port 0 write did not land");

	chk_port_isolation: assert property (@(posedge i_clk) disable iff (i_rst)
		ctl_q == DIRA_CTL_P1_WR && wr_take && hit_data
		|=> timing_q[0] == $past(timing_q[0]))
		else $error("port 1 write disturbed port 0");

	chk_port1_read: assert property (@(posedge i_clk) disable iff (i_rst)
		ctl_q == DIRA_CTL_P1_RD && rd_take && hit_data && ofs_settle
		&& !wr_take ##1 !(wr_take && hit_data)
		|-> ##1 o_rvalid && o_rdata == {1'b0, $past(timing_q[1].clk_settle, 2)})
		else $error("port 1 read returned wrong data");

	chk_read_return: assert property (@(posedge i_clk) disable iff (i_rst)
		data_rd && ofs_init
		|-> ##2 o_rvalid && o_rdata[2:0] == $past(sel_t.init_wait, 2))
		else $error("bank read did not return the register");

	chk_auto_inc: assert property (@(posedge i_clk) disable iff (i_rst)
		data_acc && ainc |=> ofs_q == $past(ofs_q) + DIRA_OFS_STEP)
		else $error("offset did not advance after data access");

	chk_term_reserved: assert property (@(posedge i_clk) disable iff (i_rst)
		data_rd && ofs_term |-> ##2 o_rvalid && o_rdata[7:3] == 5'h00)
		else $error("reserved termination bits not zero");

	chk_settle_reserved: assert property (@(posedge i_clk) disable iff (i_rst)
		data_rd && ofs_settle |-> ##2 o_rdata[7] == 1'b0)
		else $error("reserved settle bit not zero");

	chk_init_wait_min: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(o_init_done[0]) |-> elapsed_q >=
		(32'(timing_q[0].init_wait) + 32'd1) * 32'(INIT_UNIT_CYC))
		else $error("init wait ended early");

	chk_tally_clear_path: assert property (@(posedge i_clk) disable iff (i_rst)
		data_rd && ofs_tally && !i_proto_err[port] && port == 1'b0
		|=> tally_cnt[0] == DIRA_TALLY_RST)
		else $error("tally not cleared by data read");

endmodule
`default_nettype wire

// >>> src/dira_pkg.sv
package dira_pkg;

	// ==========================================================
	// Main register space
	localparam logic [7:0] DIRA_ADDR_CTL  = 8'h40;
	localparam logic [7:0] DIRA_ADDR_OFS  = 8'h41;
	localparam logic [7:0] DIRA_ADDR_DATA = 8'h42;
	localparam logic [7:0] DIRA_CTL_RST   = 8'h00;
	localparam logic [7:0] DIRA_OFS_RST   = 8'h00;
	localparam logic [7:0] DIRA_RD_NONE   = 8'h00;

	// ==========================================================
	// Control field layout and documented select values
	localparam int DIRA_CTL_RD_BIT   = 0;
	localparam int DIRA_CTL_AINC_BIT = 1;
	localparam int DIRA_CTL_P0_BIT   = 2;
	localparam int DIRA_CTL_P1_BIT   = 3;
	localparam logic [7:0] DIRA_CTL_P0_WR = 8'h04;
	localparam logic [7:0] DIRA_CTL_P1_WR = 8'h08;
	localparam logic [7:0] DIRA_CTL_P0_RD = 8'h05;
	localparam logic [7:0] DIRA_CTL_P1_RD = 8'h09;

	// ==========================================================
	// Bank offsets, widths and reset values
	localparam logic [7:0] DIRA_OFS_TALLY  = 8'h00;
	localparam logic [7:0] DIRA_OFS_INIT   = 8'h01;
	localparam logic [7:0] DIRA_OFS_TERM   = 8'h02;
	localparam logic [7:0] DIRA_OFS_SETTLE = 8'h03;
	localparam logic [7:0] DIRA_OFS_MEM    = 8'h04;
	localparam logic [7:0] DIRA_OFS_STEP   = 8'h01;
	localparam int DIRA_NPORT = 2;
	localparam int DIRA_BANK_DEPTH = 64;
	localparam logic [2:0] DIRA_INIT_RST   = 3'h0;
	localparam logic [2:0] DIRA_TERM_RST   = 3'h0;
	localparam logic [6:0] DIRA_SETTLE_RST = 7'h1d;
	localparam logic [7:0] DIRA_TALLY_RST  = 8'h00;
	localparam logic [7:0] DIRA_TALLY_MAX  = 8'hff;
	localparam logic [7:0] DIRA_TALLY_ONE  = 8'h01;

	// ==========================================================
	// Timing
	localparam int DIRA_CLK_MHZ = 125;
	localparam int DIRA_INIT_UNIT_US = 100;
	localparam int DIRA_INIT_UNIT_CYC = DIRA_INIT_UNIT_US * DIRA_CLK_MHZ;
	localparam int DIRA_SETTLE_UNIT_NS = 10;
	localparam logic [3:0] DIRA_UNIT_ONE = 4'h1;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dira_req_type;

	typedef struct packed {
		logic [2:0] init_wait;
		logic [2:0] term_count;
		logic [6:0] clk_settle;
	} dira_phy_timing_type;

	// Exactly one of the two port bits must be set
	function automatic logic dira_bank_valid(input logic [7:0] ctl);
		dira_bank_valid = ctl[DIRA_CTL_P0_BIT] ^ ctl[DIRA_CTL_P1_BIT];
	endfunction

	function automatic logic dira_bank_port(input logic [7:0] ctl);
		dira_bank_port = ctl[DIRA_CTL_P1_BIT];
	endfunction

endpackage
